/* File: design/otp_program_strobe_n_pkg.sv */
// constants and types shared by the slave programming port
// ----------------------------------------------------------------------------
// Notes on behaviour
// - sample algorithm select after reset when programming
// - program strobe honoured only in slave mode
// - strobe rising edge captures bus, starts programming
// - strobe falling edge ends current programming
// - verify output high means word programmed correctly; code also raises it in done after a dump or any other non-program command
// - verify low after rising edge means error; code holds it low for the whole pulse count, only low in done means error
// - command latch low reads command/address bus
// - programming bus is open-drain bidirectional
// ----------------------------------------------------------------------------
package otp_program_strobe_n_pkg;
  localparam int           BUS_W          = 16;
  localparam int           SEL_W          = 4;
  // algorithm select code meaning slave programming
  localparam logic [3:0]   SEL_SLAVE      = 4'hD;
  // program pulse length in ns and in cycles at 100 MHz
  localparam int           CLK_NS         = 10;
  localparam int           PROGRAM_STROBE_N_TIME_NS   = 100;
  localparam int           PROGRAM_STROBE_N_CYCLES    = (PROGRAM_STROBE_N_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int           CNT_W          = 8;
  localparam logic [7:0]   CNT_ZERO       = 8'h00;
  localparam logic [7:0]   CNT_ONE        = 8'h01;
  localparam logic [15:0]  WORD_ZERO      = 16'h0000;
  // command codes seen on the bus while the command latch is low
  localparam logic [15:0]  CMD_PROGRAM    = 16'h0001;
  localparam logic [15:0]  CMD_DUMP       = 16'h0002;
  // cycles after reset release until the filtered pins are valid
  typedef logic [2:0] settle_t;
  localparam settle_t      SETTLE_ZERO    = 3'h0;
  localparam settle_t      SETTLE_ONE     = 3'h1;
  localparam settle_t      SETTLE_LAST    = 3'h4;

  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DONE} program_strobe_n_state_t;
endpackage

/* File: design/otp_sync_if.sv */
// bundle of synchronised programming pins passed to the core
interface otp_sync_if;
  logic        strobe_n;
  logic        latch_n;
  logic        ext_access_n;
  logic [15:0] bus;
  modport src (output strobe_n, latch_n, ext_access_n, bus);
  modport dst (input  strobe_n, latch_n, ext_access_n, bus);
endinterface

/* File: design/otp_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
module otp_pin_sync #(
  parameter int W = 19
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] pins_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] s1, s2, s3, lvl, next_lvl;

  // refuse an empty synchroniser
  if (W < 1) begin : g_bad_width
    $error("otp_pin_sync: width must be positive");
  end

  // a bit changes once the second and third stages agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_lvl[i] = (s2[i] == s3[i]) ? s3[i] : lvl[i];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1  <= '1;
      s2  <= '1;
      s3  <= '1;
      lvl <= '1;
    end else begin
      s1  <= pins_i;
      s2  <= s1;
      s3  <= s2;
      lvl <= next_lvl;
    end
  end

  assign level_o = lvl;
endmodule

/* File: design/otp_slave_program_strobe_n.sv */
// slave programming port: strobe, latch, verify and open-drain bus
module otp_slave_program_strobe_n
  import otp_program_strobe_n_pkg::*;
#(
  parameter int PROGRAM_STROBE_N_CYC = PROGRAM_STROBE_N_CYCLES
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  // programming pins
  input  wire logic               external_access_n_i,
  input  wire logic [SEL_W-1:0]   programming_algorithm_select_i,
  input  wire logic               program_strobe_n_i,
  input  wire logic               command_latch_n_i,
  input  wire logic [BUS_W-1:0]   programming_word_bus_i,
  output logic      [BUS_W-1:0]   programming_word_bus_o,
  output logic      [BUS_W-1:0]   programming_word_bus_oe_o,
  output logic                    program_verify_ok_o,
  // array side
  output logic                    array_write_o,
  output logic      [BUS_W-1:0]   array_addr_o,
  output logic      [BUS_W-1:0]   array_data_o,
  input  wire logic [BUS_W-1:0]   array_rdata_i,
  // captured mode
  output logic      [SEL_W-1:0]   algorithm_o,
  output logic                    slave_mode_o
);
  // ----------------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------------
  // refuse pulse lengths the down counter cannot hold
  if (PROGRAM_STROBE_N_CYC < 1 || PROGRAM_STROBE_N_CYC > (1 << CNT_W) - 1) begin : g_bad_program_strobe_n_cyc
    $error("otp_slave_program_strobe_n: PROGRAM_STROBE_N_CYC out of range");
  end

  // positions of each pin group in the synchroniser word
  localparam int PIN_STB = BUS_W;
  localparam int PIN_LAT = BUS_W + 1;
  localparam int PIN_EXT = BUS_W + 2;
  localparam int PIN_SEL = BUS_W + 3;
  localparam int PIN_W   = PIN_SEL + SEL_W;

  // ----------------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------------
  otp_sync_if         sp ();
  logic [PIN_W-1:0]   sync_lvl;
  logic [SEL_W-1:0]   sel_lvl;

  // every pin, the algorithm select included, passes the same three stages
  otp_pin_sync #(.W(PIN_W)) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .pins_i   ({programming_algorithm_select_i, external_access_n_i, command_latch_n_i,
                program_strobe_n_i, programming_word_bus_i}),
    .level_o  (sync_lvl)
  );

  // split the filtered word back into its pin groups
  assign sp.ext_access_n = sync_lvl[PIN_EXT];
  assign sp.latch_n      = sync_lvl[PIN_LAT];
  assign sp.strobe_n     = sync_lvl[PIN_STB];
  assign sp.bus          = sync_lvl[BUS_W-1:0];
  assign sel_lvl         = sync_lvl[PIN_SEL +: SEL_W];

  // ----------------------------------------------------------------------------
  // mode capture after reset
  // ----------------------------------------------------------------------------
  logic             captured, next_captured;
  logic [SEL_W-1:0] algo, next_algo;
  logic             slave, next_slave;
  settle_t          settle, next_settle;

  // wait until the filtered pins are valid, then capture once; a capture at
  // the first edge would only see the synchroniser's reset value
  always_comb begin
    next_captured = captured;
    next_settle   = settle;
    next_algo     = algo;
    next_slave    = slave;
    if (!captured) begin
      if (settle == SETTLE_LAST) begin
        next_captured = 1'b1;
        next_algo     = sel_lvl;
        next_slave    = !sp.ext_access_n && (sel_lvl == SEL_SLAVE);
      end else begin
        next_settle   = settle + SETTLE_ONE;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      settle   <= SETTLE_ZERO;
      captured <= 1'b0;
      algo     <= '0;
      slave    <= 1'b0;
    end else begin
      settle   <= next_settle;
      captured <= next_captured;
      algo     <= next_algo;                                           // held, relies on stable pins
      slave    <= next_slave;
    end
  end

  // ----------------------------------------------------------------------------
  // strobe handshake and verify
  // ----------------------------------------------------------------------------
  program_strobe_n_state_t          state, next_state;
  logic                 strobe_d, latch_d;
  logic [CNT_W-1:0]     cnt, next_cnt;
  logic [BUS_W-1:0]     addr, next_addr, data, next_data, cmd, next_cmd;
  logic [BUS_W-1:0]     drv, next_drv;
  logic                 ok, next_ok, wr, next_wr;
  logic                 rise, fall, latch_fall;

  // strobe rising edge as seen after the synchroniser; ignored outside slave mode
  assign rise       = slave && sp.strobe_n && !strobe_d;

  always_comb begin
    fall       = slave && !sp.strobe_n && strobe_d;
    latch_fall = slave && !sp.latch_n && latch_d;
    next_state = state;
    next_cnt   = cnt;
    next_addr  = addr;
    next_data  = data;
    next_cmd   = cmd;
    next_drv   = drv;
    next_ok    = ok;
    next_wr    = 1'b0;
    // command or address taken while the latch input is low
    if (slave && !sp.latch_n) begin
      if (latch_fall) next_cmd = sp.bus;
      else            next_addr = sp.bus;
    end
    unique case (state)
      ST_IDLE: begin
        if (rise && sp.latch_n) begin
          next_data  = sp.bus;
          next_ok    = 1'b0;
          next_cnt   = CNT_W'(PROGRAM_STROBE_N_CYC);
          next_wr    = (cmd == CMD_PROGRAM);
          next_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        next_ok = 1'b0;
        if (fall) begin
          next_state = ST_IDLE;
        end else if (cnt == CNT_ONE) begin
          next_cnt   = CNT_ZERO;
          next_state = ST_DONE;
          // load the dump word so the bus shows it from the first done cycle
          if (cmd == CMD_DUMP) next_drv = array_rdata_i;
        end else begin
          next_cnt = cnt - CNT_ONE;
        end
      end
      ST_DONE: begin
        // read back and compare; low means failed word
        next_ok = (cmd != CMD_PROGRAM) || (array_rdata_i == data);
        if (cmd == CMD_DUMP) next_drv = array_rdata_i;
        if (fall) begin
          next_state = ST_IDLE;
          next_drv   = WORD_ZERO;
          next_ok    = 1'b0;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (!slave) next_ok = 1'b0;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state    <= ST_IDLE;
      strobe_d <= 1'b1;
      latch_d  <= 1'b1;
      cnt      <= CNT_ZERO;
      addr     <= WORD_ZERO;
      data     <= WORD_ZERO;
      cmd      <= WORD_ZERO;
      drv      <= WORD_ZERO;
      ok       <= 1'b0;
      wr       <= 1'b0;
    end else begin
      state    <= next_state;
      strobe_d <= sp.strobe_n;
      latch_d  <= sp.latch_n;
      cnt      <= next_cnt;
      addr     <= next_addr;
      data     <= next_data;
      cmd      <= next_cmd;
      drv      <= next_drv;
      ok       <= next_ok;
      wr       <= next_wr;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs; open-drain bus only pulls low where data bit is zero
  // ----------------------------------------------------------------------------
  logic [BUS_W-1:0] bus_oe, bus_out;
  // pull enables follow the dump word; the data side only ever pulls low
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_oe   <= WORD_ZERO;
      bus_out  <= WORD_ZERO;
    end else begin
      bus_oe   <= (slave && (cmd == CMD_DUMP) && (next_state == ST_DONE)) ? ~next_drv : WORD_ZERO;
      bus_out  <= WORD_ZERO;
    end
  end

  assign programming_word_bus_o    = bus_out;
  assign programming_word_bus_oe_o = bus_oe;
  assign program_verify_ok_o       = ok;
  assign array_write_o             = wr;
  assign array_addr_o              = addr;
  assign array_data_o              = data;
  assign algorithm_o               = algo;
  assign slave_mode_o              = slave;
endmodule

/* File: testbench/otp_program_strobe_n_checker.sv */
// assertion checker for the slave programming port
module otp_program_strobe_n_checker
  import otp_program_strobe_n_pkg::*;
#(
  parameter int PROGRAM_STROBE_N_CYC = PROGRAM_STROBE_N_CYCLES
) (
  // clock, reset and pins
  input wire logic             clk_i, resetn_i, external_access_n_i, program_strobe_n_i, command_latch_n_i,
  input wire logic [SEL_W-1:0] programming_algorithm_select_i, algorithm_o,
  input wire logic [BUS_W-1:0] programming_word_bus_i, programming_word_bus_o, programming_word_bus_oe_o,
  // verify, mode and array side
  input wire logic             program_verify_ok_o, array_write_o, slave_mode_o,
  input wire logic [BUS_W-1:0] array_addr_o, array_data_o, array_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // remember whether the last latched command was a program or not
  logic latch_q, last_cmd_program_strobe_n;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_q       <= 1'b1;
      last_cmd_program_strobe_n <= 1'b0;
    end else begin
      latch_q       <= command_latch_n_i;
      if (latch_q && !command_latch_n_i) last_cmd_program_strobe_n <= (programming_word_bus_i == CMD_PROGRAM);
    end
  end

  chk_bus_never_high: assert property (programming_word_bus_o == WORD_ZERO)
    else $error("bus output not zero");
  chk_mode_code: assert property (slave_mode_o |-> algorithm_o == SEL_SLAVE)
    else $error("slave mode with wrong code");
  chk_write_in_slave: assert property (array_write_o |-> slave_mode_o)
    else $error("write outside slave mode");
  chk_rise_starts: assert property ($rose(program_strobe_n_i) && slave_mode_o && command_latch_n_i
    && last_cmd_program_strobe_n |-> ##[3:8] array_write_o) else $error("strobe rise not captured");
  chk_data_taken: assert property (array_write_o |-> array_data_o == programming_word_bus_i)
    else $error("captured word differs from bus");
  chk_busy_low: assert property (array_write_o |=> !program_verify_ok_o [*8])
    else $error("verify high while busy");
  chk_pass_shown: assert property (array_write_o && array_rdata_i == array_data_o
    |-> ##[9:16] program_verify_ok_o) else $error("good word not verified");
  chk_fail_low: assert property ($rose(program_verify_ok_o) && last_cmd_program_strobe_n
    |-> array_rdata_i == array_data_o) else $error("verify high on bad word");
  chk_oe_dump_only: assert property (programming_word_bus_oe_o != WORD_ZERO
    |-> slave_mode_o && !last_cmd_program_strobe_n) else $error("bus pulled outside a dump");
  chk_fall_ends: assert property ($fell(program_strobe_n_i) |-> ##[1:8] !program_verify_ok_o)
    else $error("verify kept after strobe fall");
endmodule

bind otp_slave_program_strobe_n otp_program_strobe_n_checker #(.PROGRAM_STROBE_N_CYC(PROGRAM_STROBE_N_CYC)) i_chk (.clk_i, .resetn_i, .external_access_n_i,
  .program_strobe_n_i, .command_latch_n_i, .programming_algorithm_select_i, .algorithm_o,
  .programming_word_bus_i, .programming_word_bus_o, .programming_word_bus_oe_o, .program_verify_ok_o,
  .array_write_o, .slave_mode_o, .array_addr_o, .array_data_o, .array_rdata_i);

/* File: testbench/otp_programmer_model.sv */
// external programmer driving latch, strobe and the open-drain bus
module otp_programmer_model
  import otp_program_strobe_n_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             verify_i,
  input  wire logic [BUS_W-1:0] bus_i,
  output logic                  strobe_n_o,
  output logic                  latch_n_o,
  output logic      [BUS_W-1:0] drive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: strobe low, latch off, bus released to pull-ups
  initial begin
    strobe_n_o = 1'b0;
    latch_n_o = 1'b1;
    drive_o = 16'hFFFF;
  end
  // hold latch and bus for n edges
  task automatic hold(input logic l, input logic [BUS_W-1:0] v, input int n);
    @(posedge clk_i);
    latch_n_o <= l;
    drive_o <= v;
    repeat (n) @(posedge clk_i);
  endtask
  // one word: command, address, data, strobe pulse
  task automatic write_word(input logic [BUS_W-1:0] cmd, addr, data, output logic ok, output logic [BUS_W-1:0] rd);
    hold(1'b0, cmd, 4);
    hold(1'b0, addr, 6);
    hold(1'b1, data, 4);
    strobe_n_o <= 1'b1;
    for (int i = 0; i < 30 && verify_i !== 1'b1; i++) @(posedge clk_i);
    ok = verify_i;
    rd = bus_i;
    @(posedge clk_i);
    strobe_n_o <= 1'b0;
    drive_o <= 16'hFFFF;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

/* File: testbench/tb.sv */
// testbench for the slave programming port
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import otp_program_strobe_n_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, ea_n = 1'b1, strobe_n, latch_n, verify, wr, slave, ok;
  logic [SEL_W-1:0] sel = 4'h0, alg;
  logic [BUS_W-1:0] drive, bus_i, oe, bus_o, addr, data, rd, rdata = 16'h0000;
  int err_count = 0, cmp_count = 0, wr_cnt = 0;
  // open-drain bus with pull-ups
  assign bus_i = drive & ~oe;
  always #5 clk = ~clk;
  always @(posedge clk) if (wr === 1'b1) wr_cnt++;
  otp_slave_program_strobe_n #(.PROGRAM_STROBE_N_CYC(10)) i_dut (.clk_i(clk), .resetn_i(resetn), .external_access_n_i(ea_n),
    .programming_algorithm_select_i(sel), .program_strobe_n_i(strobe_n), .command_latch_n_i(latch_n),
    .programming_word_bus_i(bus_i), .programming_word_bus_o(bus_o), .programming_word_bus_oe_o(oe),
    .program_verify_ok_o(verify), .array_write_o(wr), .array_addr_o(addr), .array_data_o(data),
    .array_rdata_i(rdata), .algorithm_o(alg), .slave_mode_o(slave));
  otp_programmer_model i_program_strobe_n (.clk_i(clk), .verify_i(verify), .bus_i(bus_i), .strobe_n_o(strobe_n),
    .latch_n_o(latch_n), .drive_o(drive));
  task automatic chk(input string n, input logic [BUS_W-1:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // reset with the mode pins set, held stable afterwards
  task automatic do_reset(input logic e, input logic [SEL_W-1:0] s);
    @(posedge clk);
    resetn <= 1'b0;
    ea_n <= e;
    sel <= s;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    wr_cnt = 0;
  endtask
  // strobe must do nothing outside slave mode
  task automatic t_other_modes();
    for (int i = 0; i < 2; i++) begin
      do_reset(i == 0, i == 0 ? SEL_SLAVE : 4'h0);
      chk("slave_mode", 16'h0000, 16'(slave));
      i_program_strobe_n.write_word(CMD_PROGRAM, 16'h0010, 16'h1234, ok, rd);
      chk("write_count", 16'h0000, 16'(wr_cnt));
      chk("verify_ok", 16'h0000, 16'(ok));
    end
  endtask
  // good word programmed and verified
  task automatic t_pass();
    do_reset(1'b0, SEL_SLAVE);
    chk("algorithm", 16'(SEL_SLAVE), 16'(alg));
    rdata <= 16'hA5C3;
    i_program_strobe_n.write_word(CMD_PROGRAM, 16'h0123, 16'hA5C3, ok, rd);
    chk("write_count", 16'h0001, 16'(wr_cnt));
    chk("array_addr", 16'h0123, addr);
    chk("array_data", 16'hA5C3, data);
    chk("verify_ok", 16'h0001, 16'(ok));
  endtask
  // bad readback reported, verify still low after strobe fall
  task automatic t_fail();
    rdata <= 16'hFFFF;
    i_program_strobe_n.write_word(CMD_PROGRAM, 16'h7FFE, 16'h0F0F, ok, rd);
    chk("write_count", 16'h0002, 16'(wr_cnt));
    chk("array_addr", 16'h7FFE, addr);
    chk("verify_ok", 16'h0000, 16'(ok));
    chk("verify_idle", 16'h0000, 16'(verify));
  endtask
  // dump reads the array word back over the released open-drain bus
  task automatic t_dump();
    rdata <= 16'h3C5A;
    i_program_strobe_n.write_word(CMD_DUMP, 16'h0040, 16'hFFFF, ok, rd);
    chk("write_count", 16'h0002, 16'(wr_cnt));
    chk("array_addr", 16'h0040, addr);
    chk("dump_word", 16'h3C5A, rd);
    chk("bus_out", 16'h0000, bus_o);
    chk("oe_idle", 16'h0000, oe);
  endtask
  initial begin
    t_other_modes();
    t_pass();
    t_fail();
    t_dump();
    print_verdict();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule
